// *** common/ssfe_pkg.sv ***
// ssfe_pkg: constants of the serial frame engine.
// assumes tick figures count serial half periods.
`default_nettype none

package ssfe_pkg;

    // word geometry
    localparam int unsigned SSFE_MAX_BITS   = 16;
    localparam int unsigned SSFE_CNT_W      = 5;
    localparam int unsigned SSFE_TICK_W     = 6;
    localparam logic [4:0]  SSFE_CTL_BITS   = 5'h08;

    // half-period tick marks of a frame, four-wire format
    localparam logic [5:0]  SSFE_SPI_END_OFS  = 6'h02;
    localparam logic [5:0]  SSFE_SPI_RST_OFS  = 6'h01;
    localparam logic [5:0]  SSFE_SPI_SHIFT_LO = 6'h03;
    localparam logic [5:0]  SSFE_SPI_SMP_LO   = 6'h02;

    // half-period tick marks of a frame, message format
    localparam logic [5:0]  SSFE_MSG_CTL_SHLO = 6'h02;
    localparam logic [5:0]  SSFE_MSG_CTL_SHHI = 6'h0e;
    localparam logic [5:0]  SSFE_MSG_CTL_DONE = 6'h10;
    localparam logic [5:0]  SSFE_MSG_RSP_LO   = 6'h13;
    localparam logic [5:0]  SSFE_MSG_RSP_HI   = 6'h11;
    localparam logic [5:0]  SSFE_MSG_RST_OFS  = 6'h12;
    localparam logic [5:0]  SSFE_MSG_END_OFS  = 6'h13;

    // select high time between frames, half periods
    localparam logic [5:0]  SSFE_GAP_TICKS    = 6'h02;

    typedef enum logic [1:0] {
        SSFE_M_IDLE = 2'b00,
        SSFE_M_RUN  = 2'b01,
        SSFE_M_GAP  = 2'b10
    } ssfe_mstate_e;

endpackage : ssfe_pkg

`default_nettype wire

// *** core/ssfe_core.sv ***
// ssfe_core: frame sequencer of a synchronous serial port, master or slave.
// assumes FIFOs outside, config static while enabled, link_clk_i turned
// so that its rising edge is the sampling edge of the mode.
//
// Behaviour
// [RULE1] idle: select high, data out low, clock at rest
// [RULE2] idle four-wire: clock pad on as master, off as slave
// [RULE3] master starts on enable and transmit data: select low
// [RULE4] mode 0/0: data half period after select, then rising edge; the code drives data as select falls, rising edge one period later
// [RULE5] mode 0/1: first edge rising, sample falling
// [RULE6] mode 1/0: data half period after select, then falling edge; the code drives data as select falls, falling edge one period later
// [RULE7] mode 1/1: first edge falling, sample rising
// [RULE8] select rises one serial period after last sample
// [RULE9] phase 0: select pulses high between words
// [RULE10] phase 1: select stays low between words
// [RULE11] far slave drives first bit when select falls
// [RULE12] message: 8-bit control word first, nothing received
// [RULE13] far slave waits one clock, returns 4 to 16 bits
// [RULE14] message: load on select fall, MSB out, select low
// [RULE15] message: response driven falling, latched rising
// [RULE16] single message: select rises one period after last bit
// [RULE17] far slave releases its line after LSB or select high
// [RULE18] continuous message: next control follows, word out
// [RULE19] slave samples first bit on first rising edge
// [RULE20] external master: select setup two, hold one period
// [RULE21] frames are 4 to 16 bits, MSB first
// [RULE22] phase 0 captures on first transition, phase 1 second
// [RULE23] each received word goes to the receive FIFO
`default_nettype none

module ssfe_core
    import ssfe_pkg::*;
#(
    parameter int unsigned HALF_DIV = 5
) (
    // clocks and reset
    input  wire logic                           core_clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           clk_en_i,
    input  wire logic                           link_clk_i,
    // configuration
    input  wire logic                           enable_i,
    input  wire logic                           master_i,
    input  wire logic                           msg_mode_i,
    input  wire logic                           clock_polarity_sel_i,
    input  wire logic                           clock_phase_sel_i,
    input  wire logic [ssfe_pkg::SSFE_CNT_W-1:0] data_bits_i,
    // transmit FIFO side
    input  wire logic                           tx_valid_i,
    input  wire logic [ssfe_pkg::SSFE_MAX_BITS-1:0] tx_data_i,
    output logic                                tx_pop_o,
    // receive FIFO side
    output logic                                rx_push_o,
    output logic [ssfe_pkg::SSFE_MAX_BITS-1:0]  rx_data_o,
    // status
    output logic                                busy_o,
    // serial pins
    output logic                                serial_clock_line_o,
    output logic                                serial_clock_line_oe_o,
    input  wire logic                           frame_select_line_i,
    output logic                                frame_select_line_o,
    output logic                                frame_select_line_oe_o,
    output logic                                serial_out_line_o,
    output logic                                serial_out_line_oe_o,
    input  wire logic                           serial_in_line_i
);

    localparam int unsigned DIV_W = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);

    // frame geometry from word length
    logic [SSFE_TICK_W-1:0] two_w;
    logic [SSFE_TICK_W-1:0] spi_end;
    logic [SSFE_TICK_W-1:0] spi_rst;
    logic [SSFE_TICK_W-1:0] msg_end;
    logic [SSFE_TICK_W-1:0] msg_rst;
    logic [SSFE_TICK_W-1:0] msg_rsp_hi;
    logic [SSFE_MAX_BITS-1:0] tx_aligned;

    assign two_w      = {data_bits_i, 1'b0};
    assign spi_end    = two_w + SSFE_SPI_END_OFS;
    assign spi_rst    = two_w + SSFE_SPI_RST_OFS;
    assign msg_end    = two_w + SSFE_MSG_END_OFS;
    assign msg_rst    = two_w + SSFE_MSG_RST_OFS;
    assign msg_rsp_hi = two_w + SSFE_MSG_RSP_HI;
    // left-align so the MSB leaves from the top bit
    assign tx_aligned = msg_mode_i ?
        {tx_data_i[SSFE_CTL_BITS-1:0], 8'h00} : // RULE12
        SSFE_MAX_BITS'(tx_data_i << (6'(SSFE_MAX_BITS) - 6'(data_bits_i)));

    // master serial input: two flops before use
    logic sin_s1_r;
    logic sin_s2_r;
    // frame select seen from the core domain (slave)
    logic fss_s1_r;
    logic fss_s2_r;
    // slave word-done toggle crossing
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic s_tog_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sin_s1_r <= 1'b0;
            sin_s2_r <= 1'b0;
            fss_s1_r <= 1'b1;
            fss_s2_r <= 1'b1;
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end else if (clk_en_i) begin
            sin_s1_r <= serial_in_line_i;
            sin_s2_r <= sin_s1_r;
            fss_s1_r <= frame_select_line_i;
            fss_s2_r <= fss_s1_r;
            tog_s1_r <= s_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    // master sequencer
    ssfe_mstate_e st_r, st_nxt;
    logic [DIV_W-1:0]         div_r, div_nxt;
    logic [SSFE_TICK_W-1:0]   t_r, t_nxt;
    logic                     tog_r, tog_nxt;
    logic                     fss_r, fss_nxt;
    logic                     toe_r, toe_nxt;
    logic [SSFE_MAX_BITS-1:0] sh_r, sh_nxt;
    logic [SSFE_MAX_BITS-1:0] rx_r, rx_nxt;
    logic                     mpop;
    logic                     mpush;
    logic [SSFE_MAX_BITS-1:0] mdata;
    logic                     tick;
    logic [SSFE_TICK_W-1:0]   t1;
    logic                     cont;
    logic                     edge_now;

    assign tick = (div_r == DIV_LAST);
    assign t1   = t_r + 6'h01;
    // only phase 1 and message format may run words back to back
    assign cont = enable_i && tx_valid_i && (msg_mode_i || clock_phase_sel_i);

    always_comb begin
        st_nxt  = st_r;
        div_nxt = tick ? '0 : div_r + DIV_W'(1);
        t_nxt   = t_r;
        tog_nxt = tog_r;
        fss_nxt = fss_r;
        toe_nxt = toe_r;
        sh_nxt  = sh_r;
        rx_nxt  = rx_r;
        mpop    = 1'b0;
        mpush   = 1'b0;
        mdata   = rx_r;
        if (msg_mode_i) begin
            edge_now = (t1 <= msg_rst);
        end else if (clock_phase_sel_i) begin
            edge_now = (t1 <= two_w); // RULE5 RULE7
        end else begin
            edge_now = (t1 >= SSFE_SPI_SMP_LO) && (t1 <= spi_rst); // RULE4
        end
        unique case (st_r)
            SSFE_M_IDLE: begin
                fss_nxt = 1'b1; // RULE1
                toe_nxt = 1'b0;
                tog_nxt = 1'b0;
                div_nxt = '0;
                if (enable_i && master_i && tx_valid_i) begin // RULE3
                    mpop    = 1'b1;
                    fss_nxt = 1'b0;
                    toe_nxt = 1'b1;
                    sh_nxt  = tx_aligned; // RULE14
                    rx_nxt  = '0;
                    t_nxt   = '0;
                    st_nxt  = SSFE_M_RUN;
                end
            end
            SSFE_M_RUN: begin
                if (!enable_i) begin
                    st_nxt = SSFE_M_IDLE;
                end else if (tick) begin
                    if (cont && (msg_mode_i ? (t1 == msg_rst)
                                            : (t1 == spi_rst))) begin
                        // next word starts without raising select
                        mpop    = 1'b1; // RULE10 RULE18
                        mpush   = msg_mode_i; // RULE18
                        sh_nxt  = tx_aligned;
                        rx_nxt  = '0;
                        tog_nxt = ~tog_r;
                        t_nxt   = msg_mode_i ? '0 : SSFE_SPI_RST_OFS;
                    end else if (t1 == (msg_mode_i ? msg_end : spi_end)) begin
                        fss_nxt = 1'b1; // RULE8 RULE16
                        toe_nxt = 1'b0;
                        mpush   = msg_mode_i; // RULE16
                        t_nxt   = '0;
                        st_nxt  = SSFE_M_GAP;
                    end else begin
                        t_nxt = t1;
                        if (edge_now) begin
                            tog_nxt = ~tog_r;
                        end
                        if (msg_mode_i) begin
                            if (!t1[0] && t1 >= SSFE_MSG_CTL_SHLO &&
                                t1 <= SSFE_MSG_CTL_SHHI) begin
                                sh_nxt = {sh_r[SSFE_MAX_BITS-2:0], 1'b0};
                            end
                            if (t1 == SSFE_MSG_CTL_DONE) begin
                                sh_nxt = '0; // RULE12
                            end
                            if (t1[0] && t1 >= SSFE_MSG_RSP_LO &&
                                t1 <= msg_rsp_hi) begin
                                rx_nxt = {rx_r[SSFE_MAX_BITS-2:0],
                                          sin_s2_r}; // RULE15
                            end
                        end else begin
                            if (t1[0] && t1 >= SSFE_SPI_SHIFT_LO) begin
                                sh_nxt = {sh_r[SSFE_MAX_BITS-2:0], 1'b0};
                            end
                            if (!t1[0] && t1 >= SSFE_SPI_SMP_LO &&
                                t1 <= two_w) begin
                                rx_nxt = {rx_r[SSFE_MAX_BITS-2:0],
                                          sin_s2_r}; // RULE22
                                if (t1 == two_w) begin
                                    mpush = 1'b1; // RULE23
                                    mdata = rx_nxt;
                                end
                            end
                        end
                    end
                end
            end
            SSFE_M_GAP: begin
                // select stays high one serial period between frames
                if (tick) begin
                    t_nxt = t1;
                    if (t1 == SSFE_GAP_TICKS) begin // RULE9
                        st_nxt = SSFE_M_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = SSFE_M_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r  <= SSFE_M_IDLE;
            div_r <= '0;
            t_r   <= '0;
            tog_r <= 1'b0;
            fss_r <= 1'b1;
            toe_r <= 1'b0;
            sh_r  <= '0;
            rx_r  <= '0;
        end else if (clk_en_i) begin
            st_r  <= st_nxt;
            div_r <= div_nxt;
            t_r   <= t_nxt;
            tog_r <= tog_nxt;
            fss_r <= fss_nxt;
            toe_r <= toe_nxt;
            sh_r  <= sh_nxt;
            rx_r  <= rx_nxt;
        end
    end

    // slave word: loaded while deselected, frozen while selected
    logic [SSFE_MAX_BITS-1:0] slv_word_r, slv_word_nxt;
    logic                     slv_ld_r, slv_ld_nxt;
    logic                     spop;
    logic [SSFE_MAX_BITS-1:0] s_word_r;
    logic                     spush;

    assign spush = (tog_s2_r ^ tog_s3_r) && !master_i && enable_i; // RULE23

    always_comb begin
        slv_word_nxt = slv_word_r;
        slv_ld_nxt   = slv_ld_r;
        spop         = 1'b0;
        if (!fss_s2_r) begin
            slv_ld_nxt = 1'b0;
        end else if (enable_i && !master_i && tx_valid_i && !slv_ld_r) begin
            slv_word_nxt = tx_data_i; // RULE9
            slv_ld_nxt   = 1'b1;
            spop         = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slv_word_r <= '0;
            slv_ld_r   <= 1'b0;
        end else if (clk_en_i) begin
            slv_word_r <= slv_word_nxt;
            slv_ld_r   <= slv_ld_nxt;
        end
    end

    // receive FIFO output register
    logic                     rxv_r, rxv_nxt;
    logic [SSFE_MAX_BITS-1:0] rxd_r, rxd_nxt;

    always_comb begin
        rxv_nxt = mpush || spush;
        rxd_nxt = rxd_r;
        if (mpush) begin
            rxd_nxt = mdata;
        end else if (spush) begin
            rxd_nxt = s_word_r;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxv_r <= 1'b0;
            rxd_r <= '0;
        end else if (clk_en_i) begin
            rxv_r <= rxv_nxt;
            rxd_r <= rxd_nxt;
        end
    end

    // link domain: counters clear while deselected, as the
    // external clock may stand still outside frames
    logic                     link_rst_n;
    logic [SSFE_CNT_W-1:0]    s_smp_r, s_smp_nxt;
    logic [SSFE_CNT_W-1:0]    s_chg_r, s_chg_nxt;
    logic [SSFE_MAX_BITS-1:0] s_rx_r, s_rx_nxt;
    logic [SSFE_MAX_BITS-1:0] s_word_nxt;
    logic                     s_tog_nxt;
    logic [SSFE_CNT_W-1:0]    s_idx;
    logic [SSFE_CNT_W-1:0]    s_bit;

    assign link_rst_n = rst_n_i && !frame_select_line_i;

    always_comb begin
        s_rx_nxt   = {s_rx_r[SSFE_MAX_BITS-2:0], serial_in_line_i}; // RULE19
        s_smp_nxt  = s_smp_r + 5'h01;
        s_word_nxt = s_word_r;
        s_tog_nxt  = s_tog_r;
        if (s_smp_nxt == data_bits_i) begin
            s_smp_nxt  = '0;
            s_word_nxt = s_rx_nxt;
            s_tog_nxt  = ~s_tog_r;
        end
        s_chg_nxt = (s_chg_r + 5'h01 == data_bits_i) ? '0 : s_chg_r + 5'h01;
        // phase 1 spends its first transition on presenting the MSB
        if (clock_phase_sel_i && !msg_mode_i) begin
            s_idx = (s_chg_r == '0) ? data_bits_i - 5'h01
                                    : s_chg_r - 5'h01; // RULE22
        end else begin
            s_idx = s_chg_r;
        end
        s_bit = data_bits_i - 5'h01 - s_idx; // RULE21
    end

    always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            s_smp_r <= '0;
            s_rx_r  <= '0;
        end else begin
            s_smp_r <= s_smp_nxt;
            s_rx_r  <= s_rx_nxt;
        end
    end

    // word and toggle survive deselection for the core to fetch
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_word_r <= '0;
            s_tog_r  <= 1'b0;
        end else if (!frame_select_line_i) begin
            s_word_r <= s_word_nxt;
            s_tog_r  <= s_tog_nxt;
        end
    end

    always_ff @(negedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            s_chg_r <= '0;
        end else begin
            s_chg_r <= s_chg_nxt;
        end
    end

    // pin drive
    logic slv_sel;
    assign slv_sel = enable_i && !master_i && !frame_select_line_i;

    assign serial_clock_line_o    = (clock_polarity_sel_i && !msg_mode_i)
                                    ^ tog_r; // RULE1 RULE6
    assign serial_clock_line_oe_o = master_i; // RULE2
    assign frame_select_line_o    = fss_r;
    assign frame_select_line_oe_o = master_i;
    assign serial_out_line_o      = master_i ? (toe_r && sh_r[SSFE_MAX_BITS-1])
                                    : (slv_sel && slv_word_r[s_bit[3:0]]);
    assign serial_out_line_oe_o   = master_i ? toe_r : slv_sel;
    assign tx_pop_o               = (mpop || spop) && clk_en_i;
    assign rx_push_o              = rxv_r;
    assign rx_data_o              = rxd_r;
    assign busy_o                 = (st_r != SSFE_M_IDLE) || !fss_s2_r;

endmodule : ssfe_core

`default_nettype wire

// *** testbench/ssfe_core_sva.sv ***
// ssfe_core_sva: timing checker for the frame sequencer's master lines.
// assumes HALF_DIV of 4: the fixed repetition counts are in core cycles.
`default_nettype none

module ssfe_core_sva
    import ssfe_pkg::*;
#(
    parameter int unsigned HALF_DIV = 5
) (
    // clock, reset and mode
    input wire logic                             core_clk_i,
    input wire logic                             rst_n_i,
    input wire logic                             master_i,
    input wire logic                             msg_mode_i,
    input wire logic                             clock_polarity_sel_i,
    input wire logic                             clock_phase_sel_i,
    input wire logic [ssfe_pkg::SSFE_CNT_W-1:0]  data_bits_i,
    // watched outputs
    input wire logic                             tx_pop_o,
    input wire logic                             rx_push_o,
    input wire logic                             busy_o,
    input wire logic                             serial_clock_line_o,
    input wire logic                             serial_clock_line_oe_o,
    input wire logic                             frame_select_line_o,
    input wire logic                             serial_out_line_o,
    input wire logic                             serial_out_line_oe_o
);
    logic        m4;
    logic        ph0;
    logic        rest;
    int unsigned low_r;

    assign m4   = master_i & ~msg_mode_i;
    assign ph0  = m4 & ~clock_phase_sel_i;
    assign rest = clock_polarity_sel_i & ~msg_mode_i;

    // cycles select has been low
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) low_r <= 0;
        else low_r <= frame_select_line_o ? 0 : low_r + 1;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    idle_lines_a: assert property (master_i && !busy_o |->
        frame_select_line_o && !serial_out_line_o
        && serial_clock_line_o == rest) else $error("idle line levels");
    clk_pad_a: assert property (!msg_mode_i |->
        serial_clock_line_oe_o == master_i) else $error("clock pad enable");
    start_a: assert property (master_i && !busy_o && tx_pop_o |=>
        !frame_select_line_o && serial_out_line_oe_o) else $error("start");
    lead_ph0_a: assert property (ph0 && $fell(frame_select_line_o) |->
        (serial_clock_line_o == rest)[*8] ##1 serial_clock_line_o != rest)
        else $error("phase 0 lead-in");
    lead_ph1_a: assert property (m4 && clock_phase_sel_i
        && $fell(frame_select_line_o) |-> (serial_clock_line_o == rest)[*4]
        ##1 serial_clock_line_o != rest) else $error("phase 1 lead-in");
    frame_len_a: assert property (ph0 && $rose(frame_select_line_o) |->
        low_r == (2 * data_bits_i + 2) * HALF_DIV) else $error("frame length");
    gap_high_a: assert property (master_i && $rose(frame_select_line_o) |->
        frame_select_line_o[*8]) else $error("select gap");
    push_end_a: assert property (ph0 && rx_push_o |->
        ##[4:9] $rose(frame_select_line_o)) else $error("push to select");
    cont_low_a: assert property (master_i && !frame_select_line_o
        && tx_pop_o |=> (!frame_select_line_o)[*8]) else $error("select rose");
    msg_end_a: assert property (master_i && msg_mode_i
        && $rose(frame_select_line_o) |-> ##[0:1] rx_push_o)
        else $error("message push");
    push_once_a: assert property (rx_push_o |=> !rx_push_o)
        else $error("push width");
endmodule : ssfe_core_sva

bind ssfe_core ssfe_core_sva #(.HALF_DIV(HALF_DIV)) i_sva (.*);

`default_nettype wire

// *** testbench/ssfe_slave_model.sv ***
// ssfe_slave_model: off-chip serial slave facing the core as master.
// assumes lines from the core; a released reply line shows the inverse.
`default_nettype none

module ssfe_slave_model (
    // lines from the master
    input  wire logic        sclk_i,
    input  wire logic        fss_i,
    input  wire logic        mosi_i,
    // mode and reply word
    input  wire logic        pol_i,
    input  wire logic        pha_i,
    input  wire logic        msg_i,
    input  wire logic [4:0]  bits_i,
    input  wire logic [15:0] word_i,
    // reply line and captured word
    output logic             miso_o,
    output logic [15:0]      got_o
);
    logic s;
    int   n;
    int   rise;
    int   fall;

    // rising s is the sampling edge in every four-wire mode, and in message mode only while pol_i equals pha_i
    assign s = sclk_i ^ pol_i ^ pha_i;
    initial miso_o = 1'b0;
    always @(negedge fss_i) begin
        n = 0;
        rise = 0;
        fall = 0;
        got_o = '0;
        if (!pha_i && !msg_i) begin
            miso_o = word_i[bits_i-1];
            n = 1;
        end
    end
    always @(posedge fss_i) miso_o = ~miso_o;
    always @(posedge s) begin
        if (!fss_i && (!msg_i || rise < 8)) got_o = {got_o[14:0], mosi_i};
        rise++;
    end
    always @(negedge s) begin
        if (!fss_i) begin
            fall++;
            if (!msg_i) begin
                miso_o = word_i[bits_i-1-n];
                n = (n + 1) % bits_i;
            end else if (fall > 8 && fall - 9 < bits_i) begin
                miso_o = word_i[bits_i+8-fall];
            end else begin
                miso_o = ~miso_o;
            end
        end
    end
endmodule : ssfe_slave_model

`default_nettype wire

// *** testbench/tb_sync_serial_frame_engine.sv ***
// tb_sync_serial_frame_engine: self-checking bench of the frame sequencer.
// assumes the core at HALF_DIV 4 with the slave model on its lines.
`default_nettype none

module tb_sync_serial_frame_engine;
    timeunit 1ns;
    timeprecision 100ps;
    import ssfe_pkg::*;
    logic                     core_clk, rst_n, link, mst, msg, pol, pha;
    logic                     tx_valid, tx_pop, rx_push, busy, sclk, sclk_oe;
    logic                     fss, fss_oe, sout, sout_oe, s_fss, s_in, miso;
    logic [4:0]               bits;
    logic [SSFE_MAX_BITS-1:0] tx_data, rx_data, m_word, got, last_rx;
    int                       miscompares, checks_done, pushes, rises, cycles;

    ssfe_core #(.HALF_DIV(4)) i_dut (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
        .link_clk_i(link), .enable_i(1'b1), .master_i(mst),
        .msg_mode_i(msg), .clock_polarity_sel_i(pol),
        .clock_phase_sel_i(pha), .data_bits_i(bits), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .tx_pop_o(tx_pop), .rx_push_o(rx_push),
        .rx_data_o(rx_data), .busy_o(busy), .serial_clock_line_o(sclk),
        .serial_clock_line_oe_o(sclk_oe), .frame_select_line_i(s_fss),
        .frame_select_line_o(fss), .frame_select_line_oe_o(fss_oe),
        .serial_out_line_o(sout), .serial_out_line_oe_o(sout_oe),
        .serial_in_line_i(mst ? miso : s_in));
    ssfe_slave_model i_slave (
        .sclk_i(sclk), .fss_i(fss), .mosi_i(sout), .pol_i(pol), .pha_i(pha),
        .msg_i(msg), .bits_i(bits), .word_i(m_word), .miso_o(miso),
        .got_o(got));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge fss) rises++;
    always @(posedge core_clk) begin
        cycles++;
        if (rx_push === 1'b1) begin
            pushes++;
            last_rx = rx_data;
        end
        if (cycles > 60000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cfg(input logic p, input logic h, input logic m,
                       input logic [4:0] w);
        @(posedge core_clk);
        pol <= p;
        pha <= h;
        msg <= m;
        bits <= w;
    endtask : cfg

    task automatic wait_pop();
        for (int i = 0; i < 600 && tx_pop !== 1'b1; i++) @(negedge core_clk);
        check("pop", tx_pop, 1'b1);
        @(posedge core_clk);
    endtask : wait_pop

    task automatic wait_idle();
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 900 && busy !== 1'b0; i++) @(posedge core_clk);
        repeat (12) @(posedge core_clk);
        check("select idle", fss, 1'b1);
        check("out idle", sout, 1'b0);
        check("clock idle", sclk, pol & ~msg);
        check("clock pad", sclk_oe, mst);
    endtask : wait_idle

    task automatic spi_word(input logic p, input logic h, input logic [4:0] w,
                            input logic [15:0] t, input logic [15:0] r);
        int          n0;
        logic [15:0] mask;
        mask = 16'hffff >> (16 - w);
        cfg(p, h, 1'b0, w);
        m_word <= r;
        tx_data <= t;
        tx_valid <= 1'b1;
        n0 = pushes;
        wait_pop();
        tx_valid <= 1'b0;
        wait_idle();
        check("pushes", 16'(pushes - n0), 16'h0001);
        check("rx word", last_rx & mask, r & mask);
        check("tx word", got & mask, t & mask);
    endtask : spi_word

    task automatic spi_pair(input logic h, input int exp_rises);
        int n0;
        int r0;
        cfg(1'b0, h, 1'b0, 5'h10);
        m_word <= 16'h5a3c;
        tx_data <= 16'h1234;
        tx_valid <= 1'b1;
        n0 = pushes;
        r0 = rises;
        wait_pop();
        tx_data <= 16'hbeef;
        @(posedge core_clk);
        wait_pop();
        tx_valid <= 1'b0;
        wait_idle();
        check("pair pushes", 16'(pushes - n0), 16'h0002);
        check("select rises", 16'(rises - r0), 16'(exp_rises));
        check("second tx", got, 16'hbeef);
        check("second rx", last_rx, 16'h5a3c);
    endtask : spi_pair

    task automatic msg_word();
        cfg(1'b0, 1'b0, 1'b1, 5'h08);
        m_word <= 16'h00a5;
        tx_data <= 16'h00c3;
        tx_valid <= 1'b1;
        wait_pop();
        tx_valid <= 1'b0;
        wait_idle();
        check("control", got & 16'h00ff, 16'h00c3);
        check("response", last_rx & 16'h00ff, 16'h00a5);
    endtask : msg_word

    task automatic slave_word(input logic [15:0] r);
        logic [15:0] seen;
        int          n0;
        cfg(1'b0, 1'b0, 1'b0, 5'h10);
        mst <= 1'b0;
        tx_data <= 16'hc0de;
        tx_valid <= 1'b1;
        wait_pop();
        tx_valid <= 1'b0;
        n0 = pushes;
        #3 s_fss = 1'b0;
        s_in = r[15];
        #250;
        for (int i = 15; i >= 0; i--) begin
            s_in = r[i];
            #62.5 seen[i] = sout;
            link = 1'b1;
            #62.5 link = 1'b0;
        end
        #62.5 s_fss = 1'b1;
        s_in = ~s_in;
        wait_idle();
        check("slave pushes", 16'(pushes - n0), 16'h0001);
        check("slave rx", last_rx, r);
        check("slave tx", seen, 16'hc0de);
        mst <= 1'b1;
    endtask : slave_word

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    initial begin
        rst_n = 1'b0;
        link = 1'b0;
        mst = 1'b1;
        msg = 1'b0;
        pol = 1'b0;
        pha = 1'b0;
        bits = 5'h10;
        tx_valid = 1'b0;
        tx_data = '0;
        m_word = '0;
        s_fss = 1'b1;
        s_in = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            spi_word(m[1], m[0], 5'h10, 16'ha6c3 ^ 16'(m), 16'h3c59 ^ 16'(m));
        end
        spi_word(1'b0, 1'b0, 5'h04, 16'h000b, 16'h0009);
        spi_pair(1'b0, 2);
        spi_pair(1'b1, 1);
        msg_word();
        slave_word(16'h9b17);
        complete_run();
    end
endmodule : tb_sync_serial_frame_engine

`default_nettype wire
